// [design/rtb_host_end.sv]
// Local design decision: register access over AXI4-Lite.
`default_nettype none
module rtb_host_end
  import rtb_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        rstn,
  rtb_spi_if.host          spi,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);
  rtb_hstate_t      state_r;
  logic [2:0]       div_r;
  logic [2:0]       bit_r;
  logic [3:0]       byte_r;
  logic [7:0]       xcmd_r;
  logic [3:0]       xlen_r;
  logic [87:0]      xdat_r;
  logic [6:0]       rx_sh_r;
  logic [7:0]       status_byte_r;
  logic [31:0]      rxd_r;
  logic             csn_r;
  logic             sck_r;
  logic             mosi_r;
  logic [15:0]      sw_cmd_r;
  logic [2:0][31:0] txw_r;
  logic             raw_go_r;
  logic             init_req_r;
  logic             init_act_r;
  logic             init_done_r;
  logic             entry_b1_r;
  logic [3:0]       step_r;
  logic             aw_got_r;
  logic             w_got_r;
  logic [7:0]       awaddr_q_r;
  logic [31:0]      wdata_q_r;
  logic [3:0]       wstrb_q_r;
  logic             awready_r;
  logic             wready_r;
  logic             bvalid_r;
  logic [1:0]       bresp_r;
  logic             arready_r;
  logic             rvalid_r;
  logic [31:0]      rdata_r;
  logic [1:0]       rresp_r;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[8 * i +: 8] = nw[8 * i +: 8];
      end
    end
    return res;
  endfunction

  function automatic logic [7:0] tx_byte(input logic [7:0] cmd, input logic [87:0] dat,
                                         input logic [3:0] k);
    logic [87:0] s;
    s = dat >> {k - 4'h1, 3'b000};
    return (k == 4'h0) ? cmd : s[7:0];
  endfunction

  function automatic rtb_xfer_t wr_word(input logic [4:0] a, input logic [31:0] v);
    return '{cmd: CMD_WR_BASE | {3'h0, a}, len: WORD_BYTES, data: 88'(v)};
  endfunction

  // The fixed bring-up sequence for the tuning bank, one transfer per step.
  function automatic rtb_xfer_t init_step(input logic [3:0] s, input logic cw,
                                          input logic fast);
    case (s)
      4'h0:    return '{cmd: CMD_NOP, len: 4'h0, data: 88'h0};
      4'h1:    return '{cmd: CMD_TOGGLE, len: 4'h1, data: 88'(TOGGLE_KEY)};
      4'h2:    return wr_word(ADDR_TUNE_A, INIT_TUNE_A);
      4'h3:    return wr_word(ADDR_TUNE_B, INIT_TUNE_B);
      4'h4:    return wr_word(ADDR_TUNE_C, INIT_TUNE_C);
      4'h5:    return wr_word(ADDR_TUNE_D, INIT_TUNE_D);
      4'h6:    return wr_word(ADDR_SENS, cw ? INIT_SENS_CW : INIT_SENS);
      4'h7:    return wr_word(ADDR_CDET, INIT_CDET);
      4'h8:    return wr_word(ADDR_PLL, fast ? INIT_PLL_FAST : INIT_PLL);
      4'h9:    return wr_word(ADDR_EXT, INIT_EXT);
      4'ha:    return '{cmd: CMD_WR_BASE | {3'h0, ADDR_RAMP}, len: RAMP_BYTES,
                        data: INIT_RAMP};
      default: return '{cmd: CMD_TOGGLE, len: 4'h1, data: 88'(TOGGLE_KEY)};
    endcase
  endfunction

  logic      div_hit;
  logic      busy;
  logic      skip;
  logic      launch;
  logic      xfer_done;
  logic      rx_full_bit;
  rtb_xfer_t cur;
  logic [7:0]  byte_now;
  logic [7:0]  byte_next;
  logic [31:0] cmd_mrg;
  assign div_hit   = div_r == SCK_HALF_CYC - 3'h1;
  assign busy      = state_r != HS_IDLE || raw_go_r || init_req_r || init_act_r;
  // Toggle steps are skipped when the tuning bank was already active at entry.
  assign skip      = (step_r == 4'h1 || step_r == INIT_LAST) && entry_b1_r;
  assign launch    = state_r == HS_IDLE &&
                     (raw_go_r || (init_act_r && !skip && step_r <= INIT_LAST));
  assign xfer_done = state_r == HS_TAIL && div_hit;
  assign rx_full_bit = spi.miso;
  assign byte_now    = tx_byte(xcmd_r, xdat_r, byte_r);
  assign byte_next   = tx_byte(xcmd_r, xdat_r, byte_r + 4'h1);
  assign cmd_mrg     = merge({16'h0, sw_cmd_r}, wdata_q_r, wstrb_q_r);
  assign cur = raw_go_r ? rtb_xfer_t'{cmd: sw_cmd_r[7:0], len: sw_cmd_r[11:8],
                                      data: {txw_r[2][23:0], txw_r[1], txw_r[0]}}
                        : init_step(step_r, sw_cmd_r[HCMD_CW], sw_cmd_r[HCMD_FASTPLL]);

  // Mode 0 framing: data settles while SCK is low, both ends sample on the rise.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      state_r <= HS_IDLE;
      div_r   <= 3'h0;
      bit_r   <= 3'h0;
      byte_r  <= 4'h0;
      xcmd_r  <= 8'h0;
      xlen_r  <= 4'h0;
      xdat_r  <= 88'h0;
      csn_r   <= 1'b1;
      sck_r   <= 1'b0;
      mosi_r  <= 1'b0;
    end else begin
      div_r <= (state_r == HS_IDLE || div_hit) ? 3'h0 : div_r + 3'h1;
      case (state_r)
        HS_IDLE: begin
          if (launch) begin
            xcmd_r  <= cur.cmd;
            xlen_r  <= cur.len;
            xdat_r  <= cur.data;
            csn_r   <= 1'b0;
            mosi_r  <= cur.cmd[7];
            bit_r   <= 3'h0;
            byte_r  <= 4'h0;
            state_r <= HS_LEAD;
          end
        end
        HS_LEAD, HS_LOW: begin
          if (div_hit) begin
            sck_r   <= 1'b1;
            state_r <= HS_HIGH;
          end
        end
        HS_HIGH: begin
          if (div_hit) begin
            sck_r <= 1'b0;
            bit_r <= bit_r + 3'h1;
            if (bit_r == 3'h7 && byte_r == xlen_r) begin
              state_r <= HS_TAIL;
            end else if (bit_r == 3'h7) begin
              byte_r  <= byte_r + 4'h1;
              mosi_r  <= byte_next[7];
              state_r <= HS_LOW;
            end else begin
              mosi_r  <= byte_now[3'h6 - bit_r];
              state_r <= HS_LOW;
            end
          end
        end
        HS_TAIL: begin
          if (div_hit) begin
            csn_r   <= 1'b1;
            state_r <= HS_IDLE;
          end
        end
        default: begin
          csn_r   <= 1'b1;
          sck_r   <= 1'b0;
          state_r <= HS_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      rx_sh_r       <= 7'h0;
      status_byte_r <= 8'h0;
      rxd_r         <= 32'h0;
    end else if ((state_r == HS_LEAD || state_r == HS_LOW) && div_hit) begin
      rx_sh_r <= {rx_sh_r[5:0], rx_full_bit};
      if (bit_r == 3'h7 && byte_r == 4'h0) begin
        status_byte_r <= {rx_sh_r, rx_full_bit};
      end else if (bit_r == 3'h7 && byte_r <= WORD_BYTES) begin
        rxd_r[{byte_r[1:0] - 2'h1, 3'b000} +: 8] <= {rx_sh_r, rx_full_bit};
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      init_act_r  <= 1'b0;
      init_done_r <= 1'b0;
      entry_b1_r  <= 1'b0;
      step_r      <= 4'h0;
    end else if (init_req_r && !init_act_r) begin
      init_act_r  <= 1'b1;
      init_done_r <= 1'b0;
      step_r      <= 4'h0;
    end else if (init_act_r) begin
      if (step_r > INIT_LAST) begin
        init_act_r  <= 1'b0;
        init_done_r <= 1'b1;
      end else if (state_r == HS_IDLE && skip) begin
        step_r <= step_r + 4'h1;
      end else if (xfer_done) begin
        step_r <= step_r + 4'h1;
        if (step_r == 4'h0) begin
          entry_b1_r <= status_byte_r[BANK_BIT];
        end
      end
    end
  end

  // A start request while a transfer or sequence runs is dropped silently.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      aw_got_r   <= 1'b0;
      w_got_r    <= 1'b0;
      awaddr_q_r <= 8'h0;
      wdata_q_r  <= 32'h0;
      wstrb_q_r  <= 4'h0;
      awready_r  <= 1'b1;
      wready_r   <= 1'b1;
      bvalid_r   <= 1'b0;
      bresp_r    <= RESP_OKAY;
      sw_cmd_r   <= 16'h0;
      txw_r      <= '0;
      raw_go_r   <= 1'b0;
      init_req_r <= 1'b0;
    end else begin
      if (launch && raw_go_r) begin
        raw_go_r <= 1'b0;
      end
      if (init_act_r) begin
        init_req_r <= 1'b0;
      end
      if (s_axi_awvalid && awready_r) begin
        aw_got_r   <= 1'b1;
        awaddr_q_r <= s_axi_awaddr;
        awready_r  <= 1'b0;
      end
      if (s_axi_wvalid && wready_r) begin
        w_got_r   <= 1'b1;
        wdata_q_r <= s_axi_wdata;
        wstrb_q_r <= s_axi_wstrb;
        wready_r  <= 1'b0;
      end
      if (aw_got_r && w_got_r && !bvalid_r) begin
        aw_got_r <= 1'b0;
        w_got_r  <= 1'b0;
        bvalid_r <= 1'b1;
        bresp_r  <= RESP_OKAY;
        case (awaddr_q_r)
          HREG_CMD: begin
            sw_cmd_r <= {cmd_mrg[15:14], 2'b00, cmd_mrg[11:0]};
            if (wstrb_q_r[1] && !busy && wdata_q_r[HCMD_RAW_GO]) begin
              raw_go_r <= 1'b1;
            end else if (wstrb_q_r[1] && !busy && wdata_q_r[HCMD_INIT_GO]) begin
              init_req_r <= 1'b1;
            end
          end
          HREG_TXD0: txw_r[0] <= merge(txw_r[0], wdata_q_r, wstrb_q_r);
          HREG_TXD1: txw_r[1] <= merge(txw_r[1], wdata_q_r, wstrb_q_r);
          HREG_TXD2: txw_r[2] <= merge(txw_r[2], wdata_q_r, wstrb_q_r);
          HREG_STATUS, HREG_RXD: bresp_r <= RESP_OKAY;
          default: bresp_r <= RESP_DECERR;
        endcase
      end
      if (bvalid_r && s_axi_bready) begin
        bvalid_r  <= 1'b0;
        awready_r <= 1'b1;
        wready_r  <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      arready_r <= 1'b1;
      rvalid_r  <= 1'b0;
      rdata_r   <= 32'h0;
      rresp_r   <= RESP_OKAY;
    end else if (s_axi_arvalid && arready_r) begin
      arready_r <= 1'b0;
      rvalid_r  <= 1'b1;
      rresp_r   <= RESP_OKAY;
      case (s_axi_araddr)
        HREG_CMD:    rdata_r <= {16'h0, sw_cmd_r};
        HREG_TXD0:   rdata_r <= txw_r[0];
        HREG_TXD1:   rdata_r <= txw_r[1];
        HREG_TXD2:   rdata_r <= txw_r[2];
        HREG_STATUS: rdata_r <= {15'h0, status_byte_r[BANK_BIT], status_byte_r,
                                 6'h0, init_done_r, busy};
        HREG_RXD:    rdata_r <= rxd_r;
        default: begin
          rdata_r <= 32'h0;
          rresp_r <= RESP_DECERR;
        end
      endcase
    end else if (rvalid_r && s_axi_rready) begin
      rvalid_r  <= 1'b0;
      arready_r <= 1'b1;
    end
  end

  assign spi.csn       = csn_r;
  assign spi.sck       = sck_r;
  assign spi.mosi      = mosi_r;
  assign s_axi_awready = awready_r;
  assign s_axi_wready  = wready_r;
  assign s_axi_bvalid  = bvalid_r;
  assign s_axi_bresp   = bresp_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rvalid  = rvalid_r;
  assign s_axi_rdata   = rdata_r;
  assign s_axi_rresp   = rresp_r;
endmodule
`default_nettype wire

// [inc/rtb_pkg.sv]
`default_nettype none
package rtb_pkg;
  localparam int CLK_HZ     = 40_000_000;
  localparam int SCK_MAX_HZ = 8_000_000;
  // Half of the shortest SCK period allowed, rounded up to whole cycles.
  localparam logic [2:0] SCK_HALF_CYC = 3'((CLK_HZ + 2 * SCK_MAX_HZ - 1) / (2 * SCK_MAX_HZ));

  localparam logic [7:0] CMD_RD_BASE  = 8'h00;
  localparam logic [7:0] CMD_WR_BASE  = 8'h20;
  localparam logic [2:0] CMD_RD_TOP   = 3'h0;
  localparam logic [2:0] CMD_WR_TOP   = 3'h1;
  localparam logic [7:0] CMD_TOGGLE   = 8'h50;
  localparam logic [7:0] TOGGLE_KEY   = 8'h53;
  localparam logic [7:0] CMD_NOP      = 8'hff;

  localparam logic [4:0] ADDR_TUNE_A  = 5'h00;
  localparam logic [4:0] ADDR_TUNE_B  = 5'h01;
  localparam logic [4:0] ADDR_TUNE_C  = 5'h02;
  localparam logic [4:0] ADDR_TUNE_D  = 5'h03;
  localparam logic [4:0] ADDR_SENS    = 5'h04;
  localparam logic [4:0] ADDR_CDET    = 5'h05;
  localparam logic [4:0] ADDR_RSVD7   = 5'h07;
  localparam logic [4:0] ADDR_ID      = 5'h08;
  localparam logic [4:0] ADDR_PLL     = 5'h0c;
  localparam logic [4:0] ADDR_EXT     = 5'h0d;
  localparam logic [4:0] ADDR_RAMP    = 5'h0e;
  localparam logic [3:0] WORD_BYTES   = 4'h4;
  localparam logic [3:0] RAMP_BYTES   = 4'hb;

  localparam logic [31:0] INIT_TUNE_A   = 32'h404b01e2;
  localparam logic [31:0] INIT_TUNE_B   = 32'hc04b0000;
  localparam logic [31:0] INIT_TUNE_C   = 32'hd0fc8c02;
  localparam logic [31:0] INIT_TUNE_D   = 32'h99003941;
  localparam logic [31:0] INIT_SENS     = 32'hd99e860b;
  localparam logic [31:0] INIT_SENS_CW  = 32'hd99e8621;
  localparam logic [31:0] INIT_CDET     = 32'h24067fa6;
  localparam logic [31:0] INIT_PLL      = 32'h05731200;
  localparam logic [31:0] INIT_PLL_FAST = 32'h00731200;
  localparam logic [31:0] INIT_EXT      = 32'h0080b436;
  localparam logic [87:0] INIT_RAMP     = 88'hffef7df208082082041041;

  localparam int SENS_BIT   = 21;
  localparam int TXLVL_BIT  = 20;
  localparam int SSDIS_BIT  = 18;
  localparam int CDTH_LSB   = 26;
  localparam int PLLST_LSB  = 24;
  localparam int COMPAT_BIT = 9;
  localparam int BANK_BIT   = 7;

  localparam logic [31:0] RST_TUNE_D = 32'h03001200;
  localparam logic [31:0] RST_SENS   = 32'h00100000;
  localparam logic [31:0] RST_CDET   = 32'h24000000;
  localparam logic [31:0] RST_PLL    = 32'h05000200;
  // Arbitrary identification value.
  localparam logic [31:0] DEF_DEVICE_IDENTIFIER = 32'h000000a5;

  localparam logic [7:0] HREG_CMD    = 8'h00;
  localparam logic [7:0] HREG_TXD0   = 8'h04;
  localparam logic [7:0] HREG_TXD1   = 8'h08;
  localparam logic [7:0] HREG_TXD2   = 8'h0c;
  localparam logic [7:0] HREG_STATUS = 8'h10;
  localparam logic [7:0] HREG_RXD    = 8'h14;
  localparam int HCMD_RAW_GO  = 12;
  localparam int HCMD_INIT_GO = 13;
  localparam int HCMD_CW      = 14;
  localparam int HCMD_FASTPLL = 15;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;
  localparam logic [3:0] INIT_LAST   = 4'hb;

  typedef struct packed {
    logic [7:0]  cmd;
    logic [3:0]  len;
    logic [87:0] data;
  } rtb_xfer_t;

  typedef enum logic [2:0] {
    HS_IDLE = 3'h0,
    HS_LEAD = 3'h1,
    HS_HIGH = 3'h3,
    HS_LOW  = 3'h2,
    HS_TAIL = 3'h6
  } rtb_hstate_t;
endpackage
`default_nettype wire

// [inc/rtb_spi_if.sv]
`default_nettype none
interface rtb_spi_if;
  logic csn;
  logic sck;
  logic mosi;
  logic miso_o;
  logic miso_oe;
  wire  miso;
  // An undriven data-out line floats high through the board pull-up.
  assign miso = miso_oe ? miso_o : 1'b1;
  modport dev  (input csn, input sck, input mosi, output miso_o, output miso_oe);
  modport host (output csn, output sck, output mosi, input miso);
endinterface
`default_nettype wire

// [design/rtb_dev_end.sv]
`default_nettype none
module rtb_dev_end
  import rtb_pkg::*;
#(
  parameter logic [31:0] DEVICE_IDENTIFIER = DEF_DEVICE_IDENTIFIER
) (
  input  wire logic               clk_sys,
  input  wire logic               rstn,
  rtb_spi_if.dev                  spi,
  output logic                    bank_select_state,
  output logic                    sensitivity_high,
  output logic                    transmit_level_select,
  output logic                    signal_strength_disable,
  output logic [3:0]              carrier_detect_threshold,
  output logic [2:0]              pll_settle_code,
  output logic                    compat_dynamic,
  output logic [7:0][31:0]        tuning_word,
  output logic [87:0]             power_curve
);
  logic [7:0][31:0] word_r;
  logic [87:0]      ramp_r;
  logic             bank_r;
  logic             sck_q_r;
  logic             csn_q_r;
  logic [2:0]       bit_cnt_r;
  logic [6:0]       rx_sh_r;
  logic [3:0]       byte_idx_r;
  logic [7:0]       cmd_r;
  logic [87:0]      data_sr_r;
  logic [7:0]       out_byte_r;
  logic             miso_r;
  logic             miso_oe_r;

  // Word slots: addresses 0x00..0x05 map to 0..5, 0x0c and 0x0d to 6 and 7.
  function automatic logic [3:0] slot_of(input logic [4:0] a);
    if (a <= ADDR_CDET) begin
      return {1'b1, a[2:0]};
    end else if (a == ADDR_PLL || a == ADDR_EXT) begin
      return {1'b1, 2'b11, a[0]};
    end
    return 4'h0;
  endfunction

  function automatic logic [31:0] rd_word(input logic bank, input logic [7:0] cmd);
    if (!bank || cmd[7:5] != CMD_RD_TOP) begin
      return 32'h0;
    end else if (cmd[4:0] == ADDR_ID) begin
      return DEVICE_IDENTIFIER;
    end else if (cmd[4:0] == ADDR_RSVD7) begin
      return 32'(bank) << BANK_BIT;
    end
    return 32'h0;
  endfunction

  logic       sck_rise;
  logic       sck_fall;
  logic       cs_start;
  logic       byte_done;
  logic [7:0] new_byte;
  logic [3:0] wslot;
  logic [31:0] rd_now;
  assign sck_rise  = !spi.csn && spi.sck && !sck_q_r;
  assign sck_fall  = !spi.csn && !spi.sck && sck_q_r;
  assign cs_start  = !spi.csn && csn_q_r;
  assign byte_done = sck_rise && bit_cnt_r == 3'h7;
  assign new_byte  = {rx_sh_r, spi.mosi};
  assign wslot     = slot_of(cmd_r[4:0]);
  assign rd_now    = rd_word(bank_r, cmd_r);

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      sck_q_r <= 1'b0;
      csn_q_r <= 1'b1;
    end else begin
      sck_q_r <= spi.sck;
      csn_q_r <= spi.csn;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      bit_cnt_r  <= 3'h0;
      rx_sh_r    <= 7'h0;
      byte_idx_r <= 4'h0;
      cmd_r      <= 8'h0;
      data_sr_r  <= 88'h0;
    end else if (spi.csn) begin
      bit_cnt_r  <= 3'h0;
      byte_idx_r <= 4'h0;
    end else if (sck_rise) begin
      bit_cnt_r <= bit_cnt_r + 3'h1;
      rx_sh_r   <= new_byte[6:0];
      if (byte_done) begin
        if (byte_idx_r != 4'hf) begin
          byte_idx_r <= byte_idx_r + 4'h1;
        end
        if (byte_idx_r == 4'h0) begin
          cmd_r <= new_byte;
        end else begin
          data_sr_r <= {new_byte, data_sr_r[87:8]};
        end
      end
    end
  end

  // Data bytes go out low byte first; the status byte always leads the frame.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      out_byte_r <= 8'h0;
      miso_r     <= 1'b0;
      miso_oe_r  <= 1'b0;
    end else begin
      miso_oe_r <= !spi.csn;
      if (cs_start) begin
        out_byte_r <= {bank_r, 7'h0};
        miso_r     <= bank_r;
      end else if (byte_done) begin
        if (byte_idx_r == 4'h0) begin
          out_byte_r <= 8'(rd_word(bank_r, new_byte));
        end else if (byte_idx_r < WORD_BYTES) begin
          out_byte_r <= 8'(rd_now >> {byte_idx_r[1:0], 3'b000});
        end else begin
          out_byte_r <= 8'h0;
        end
      end else if (sck_fall) begin
        miso_r <= out_byte_r[3'h7 - bit_cnt_r];
      end
    end
  end

  // Writes land only while the tuning bank is active; in the other bank they are ignored.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      word_r    <= '0;
      word_r[3] <= RST_TUNE_D;
      word_r[4] <= RST_SENS;
      word_r[5] <= RST_CDET;
      word_r[6] <= RST_PLL;
      ramp_r    <= 88'h0;
    end else if (byte_done && bank_r && cmd_r[7:5] == CMD_WR_TOP) begin
      if (wslot[3] && byte_idx_r == WORD_BYTES) begin
        word_r[wslot[2:0]] <= {new_byte, data_sr_r[87:64]};
      end
      if (cmd_r[4:0] == ADDR_RAMP && byte_idx_r == RAMP_BYTES) begin
        ramp_r <= {new_byte, data_sr_r[87:8]};
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      bank_r <= 1'b0;
    end else if (byte_done && byte_idx_r == 4'h1 && cmd_r == CMD_TOGGLE &&
                 new_byte == TOGGLE_KEY) begin
      bank_r <= ~bank_r;
    end
  end

  assign spi.miso_o               = miso_r;
  assign spi.miso_oe              = miso_oe_r;
  assign bank_select_state        = bank_r;
  assign sensitivity_high         = word_r[4][SENS_BIT];
  assign transmit_level_select    = word_r[4][TXLVL_BIT];
  assign signal_strength_disable  = word_r[5][SSDIS_BIT];
  assign carrier_detect_threshold = word_r[5][CDTH_LSB +: 4];
  assign pll_settle_code          = word_r[6][PLLST_LSB +: 3];
  assign compat_dynamic           = word_r[6][COMPAT_BIT];
  assign tuning_word              = word_r;
  assign power_curve              = ramp_r;
endmodule
`default_nettype wire

// [testbench/rtb_link_sva.sv]
`default_nettype none
module rtb_link_sva (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic csn,
  input wire logic sck,
  input wire logic mosi,
  input wire logic miso_o,
  input wire logic miso_oe,
  input wire logic miso
);
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (!rstn);
  a_sck_idle_low: assert property (csn |-> !sck)
    else $error("sck active outside frame");
  a_oe_follows_cs: assert property (miso_oe == !$past(csn))
    else $error("miso enable not one cycle behind select");
  a_miso_moves: assert property ($changed(miso_o) |->
    !$past(sck) && ($past(sck, 2) || $past(csn, 2)))
    else $error("device data moved off a falling sck or select");
  a_sck_high_half: assert property ($rose(sck) |-> sck [*3] ##1 !sck)
    else $error("sck high phase not three cycles");
  a_sck_low_half: assert property ($fell(sck) |-> !sck [*3])
    else $error("sck low phase too short");
  a_cs_lead: assert property ($fell(csn) |-> !sck [*3] ##1 sck)
    else $error("select lead time wrong");
  a_cs_tail: assert property ($rose(csn) |-> !$past(sck) && !$past(sck, 2) &&
    !$past(sck, 3))
    else $error("select tail time too short");
  a_mosi_held: assert property (sck && $past(sck) |-> $stable(mosi))
    else $error("host data moved while sck high");
  a_miso_held: assert property (sck && $past(sck) |-> $stable(miso_o))
    else $error("device data moved while sck high");
endmodule
`default_nettype wire

// [testbench/radio_tuning_register_bank_tb.sv]
`default_nettype none
module radio_tuning_register_bank_tb import rtb_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_sys = 1'b0, rstn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic bank_select_state, sensitivity_high, transmit_level_select;
  logic signal_strength_disable, compat_dynamic;
  logic [3:0] carrier_detect_threshold;
  logic [2:0] pll_settle_code;
  logic [7:0][31:0] tuning_word;
  logic [87:0] power_curve;
  int fails = 0, n_compared = 0;
  rtb_spi_if spi ();
  rtb_host_end i_rtb_host_end (.spi(spi), .*);
  rtb_dev_end i_rtb_dev_end (.spi(spi), .*);
  rtb_link_sva i_rtb_link_sva (.clk_sys, .rstn, .csn(spi.csn), .sck(spi.sck), .mosi(spi.mosi),
    .miso_o(spi.miso_o), .miso_oe(spi.miso_oe), .miso(spi.miso));
  initial forever #12.5 clk_sys = ~clk_sys;
  task automatic summarize;
    $display("compared %0d, failed %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [87:0] got, input logic [87:0] exp);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %s exp %h got %h", nm, exp, got);
    end
  endtask
  task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int k;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (k = 0; k < 100; k++) begin
      @(posedge clk_sys);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid === 1'b1) break;
    end
    s_axi_bready <= 1'b0;
    chk("bresp", s_axi_bresp, er);
    if (k == 100) begin
      fails++;
      summarize;
    end
    @(posedge clk_sys);
  endtask
  task automatic axr(input logic [7:0] a, input logic [1:0] er);
    int k;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (k = 0; k < 100; k++) begin
      @(posedge clk_sys);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1) break;
    end
    s_axi_rready <= 1'b0;
    rd = s_axi_rdata;
    chk("rresp", s_axi_rresp, er);
    if (k == 100) begin
      fails++;
      summarize;
    end
    @(posedge clk_sys);
  endtask
  // Polls busy; the bound covers the longest initialisation run.
  task automatic idle;
    int k;
    for (k = 0; k < 3000; k++) begin
      axr(HREG_STATUS, RESP_OKAY);
      if (rd[0] === 1'b0) break;
    end
    if (k == 3000) begin
      fails++;
      summarize;
    end
  endtask
  task automatic raw(input logic [7:0] c, input logic [3:0] n, input logic [31:0] d);
    axw(HREG_TXD0, d, RESP_OKAY);
    axw(HREG_CMD, {16'h0, 4'h1, n, c}, RESP_OKAY);
    idle;
  endtask
  task automatic t_reset;
    chk("bank", bank_select_state, 1'b0);
    chk("txlvl", transmit_level_select, 1'b1);
    chk("cdth", carrier_detect_threshold, 4'h9);
    chk("pllc", pll_settle_code, 3'h5);
    chk("compat", compat_dynamic, 1'b1);
    chk("w3", tuning_word[3], RST_TUNE_D);
    axr(8'h40, RESP_DECERR);
    axw(8'h40, 32'h0, RESP_DECERR);
  endtask
  task automatic t_bank;
    raw(CMD_WR_BASE | ADDR_SENS, WORD_BYTES, 32'h00200000);
    chk("ign", sensitivity_high, 1'b0);
    raw(CMD_TOGGLE, 4'h1, 32'(TOGGLE_KEY));
    chk("bank1", bank_select_state, 1'b1);
    raw(CMD_RD_BASE | ADDR_ID, WORD_BYTES, 32'h0);
    axr(HREG_RXD, RESP_OKAY);
    chk("id", rd, DEF_DEVICE_IDENTIFIER);
    axr(HREG_STATUS, RESP_OKAY);
    chk("stat", rd[16:8], 9'h180);
    raw(CMD_RD_BASE | ADDR_RSVD7, WORD_BYTES, 32'h0);
    axr(HREG_RXD, RESP_OKAY);
    chk("rsv7", rd, 32'h80);
    raw(CMD_WR_BASE | ADDR_ID, WORD_BYTES, 32'h5a5a1234);
    raw(CMD_RD_BASE | ADDR_ID, WORD_BYTES, 32'h0);
    axr(HREG_RXD, RESP_OKAY);
    chk("id2", rd, DEF_DEVICE_IDENTIFIER);
  endtask
  // Starting in the tuning bank, the sequence must not toggle back.
  task automatic t_init;
    axw(HREG_CMD, 32'h0000e000, RESP_OKAY);
    idle;
    chk("done", rd[1], 1'b1);
    chk("w0", tuning_word[0], INIT_TUNE_A);
    chk("w1", tuning_word[1], INIT_TUNE_B);
    chk("w2", tuning_word[2], INIT_TUNE_C);
    chk("w3i", tuning_word[3], INIT_TUNE_D);
    chk("w4", tuning_word[4], INIT_SENS_CW);
    chk("w5", tuning_word[5], INIT_CDET);
    chk("wc", tuning_word[6], INIT_PLL_FAST);
    chk("pll0", pll_settle_code, 3'h0);
    chk("wd", tuning_word[7], INIT_EXT);
    chk("ramp", power_curve, INIT_RAMP);
    chk("bank", bank_select_state, 1'b1);
  endtask
  task automatic t_fields;
    raw(CMD_WR_BASE | ADDR_SENS, WORD_BYTES, 32'h00200000);
    chk("sens", sensitivity_high, 1'b1);
    chk("txlo", transmit_level_select, 1'b0);
    raw(CMD_WR_BASE | ADDR_CDET, WORD_BYTES, 32'h1c000000);
    chk("cdth7", carrier_detect_threshold, 4'h7);
    chk("ssen", signal_strength_disable, 1'b0);
    raw(CMD_WR_BASE | ADDR_PLL, WORD_BYTES, 32'h05000000);
    chk("compat0", compat_dynamic, 1'b0);
  endtask
  // Starting in the primary bank, the sequence toggles in and back out again.
  task automatic t_init0;
    raw(CMD_TOGGLE, 4'h1, 32'(TOGGLE_KEY));
    axw(HREG_CMD, 32'h00002000, RESP_OKAY);
    idle;
    chk("done0", rd[1], 1'b1);
    chk("w4n", tuning_word[4], INIT_SENS);
    chk("wcn", tuning_word[6], INIT_PLL);
    chk("pll5", pll_settle_code, 3'h5);
    chk("bank0", bank_select_state, 1'b0);
  endtask
  initial begin
    repeat (20) @(posedge clk_sys);
    rstn <= 1'b1;
    @(posedge clk_sys);
    t_reset;
    t_bank;
    t_init;
    t_fields;
    t_init0;
    summarize;
  end
endmodule
`default_nettype wire
